/* File: scss_pkg.sv */
/*
 * Shared constants, types and helpers of the system clock source switch.
 * Assumes a 25 MHz APB clock and a 32-bit APB bus with 12-bit byte addresses.
 */
package scss_pkg;

    // Bus clock and the timed-access window.
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned UNLOCK_WINDOW_NS = 1000;
    localparam int unsigned UNLOCK_WINDOW_CYC = (UNLOCK_WINDOW_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                                (UNLOCK_WINDOW_NS / CLK_PERIOD_NS);

    // Register indices; the byte address is four times the index.
    localparam int AW = 12;
    localparam logic [7:0] SWITCH_IDX = 8'h96;
    localparam logic [7:0] ENABLE_IDX = 8'h97;
    localparam logic [7:0] UNLOCK_IDX = 8'hA0;

    // Reset values.
    localparam logic [7:0] SWITCH_RST = 8'h30;
    localparam logic [7:0] ENABLE_RST = 8'h30;

    // Field positions of the switch register.
    localparam int SW_FAST_ST_BIT = 5;
    localparam int SW_SLOW_ST_BIT = 4;
    localparam int SW_EXT_ST_BIT = 3;
    localparam int SW_SEL_LSB = 1;

    // Field positions of the enable register.
    localparam int EN_EXT_LSB = 6;
    localparam int EN_FAST_BIT = 5;
    localparam int EN_FAULT_BIT = 0;

    // External enable code that turns the crystal input into a clock input.
    localparam logic [1:0] EXT_ON = 2'h3;

    // Unlock key sequence.
    localparam logic [7:0] UNLOCK_KEY1 = 8'hAA;
    localparam logic [7:0] UNLOCK_KEY2 = 8'h55;

    // System clock source codes.
    typedef enum logic [1:0] {
        SRC_FAST = 2'h0,
        SRC_EXT = 2'h1,
        SRC_SLOW = 2'h2,
        SRC_RSVD = 2'h3
    } scss_src_t;

    // Readiness reported by the oscillators and the clock pad.
    typedef struct packed {
        logic fast_ready;
        logic slow_ready;
        logic ext_ready;
    } scss_osc_status_t;

    // Controls driven to the oscillators, the pad and the clock mux.
    typedef struct packed {
        logic fast_en;
        logic ext_en;
        scss_src_t source;
        logic switch_pending;
    } scss_osc_ctrl_t;

    // Byte address of a register index.
    function automatic logic [AW-1:0] scss_reg_addr(input logic [7:0] idx);
        scss_reg_addr = {2'h0, idx, 2'h0};
    endfunction : scss_reg_addr

endpackage : scss_pkg

/* File: scss_timed_access.sv */
/*
 * Timed-access unlock: two key writes open a short window for one write.
 * Assumes its write strobes are one-cycle pulses of completed APB writes.
 */
`timescale 1ns/1ps

module scss_timed_access
    import scss_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic wr_any,
    input wire logic wr_key,
    input wire logic [7:0] key_data,
    output logic unlocked
);

    localparam int CW = $clog2(UNLOCK_WINDOW_CYC + 1);
    localparam logic [CW-1:0] WIN_LOAD = CW'(UNLOCK_WINDOW_CYC);

    typedef enum logic [1:0] {
        TA_IDLE,
        TA_ARMED,
        TA_OPEN
    } scss_ta_state_t;

    scss_ta_state_t state_q;
    scss_ta_state_t state_d;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;

    wire logic is_key1 = wr_key && (key_data == UNLOCK_KEY1);
    wire logic is_key2 = wr_key && (key_data == UNLOCK_KEY2);
    wire logic expired = (state_q != TA_IDLE) && (cnt_q == CW'(1));

    // Any write closes an open window, so one unlock admits at most one write.
    always_comb
    begin
        state_d = state_q;
        cnt_d = (cnt_q != '0) ? cnt_q - CW'(1) : cnt_q;
        if (expired)
        begin
            state_d = TA_IDLE;
        end
        if (wr_any)
        begin
            case (state_q)
                TA_ARMED:
                begin
                    state_d = is_key2 ? TA_OPEN : (is_key1 ? TA_ARMED : TA_IDLE);
                    cnt_d = WIN_LOAD;
                end
                default:
                begin
                    state_d = is_key1 ? TA_ARMED : TA_IDLE;
                    cnt_d = WIN_LOAD;
                end
            endcase
        end
    end

    // State and window counter.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= TA_IDLE;
            cnt_q <= '0;
        end
        else if (ce)
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    assign unlocked = (state_q == TA_OPEN);

endmodule : scss_timed_access

/* File: scss_top.sv */
/*
 * System clock source switch: selects among the fast internal oscillator,
 * the external clock input and the slow internal oscillator, enables the
 * sources, reports their stability and flags faulty switch requests.
 * Registers are reached over APB; two of them are timed-access protected.
 * Assumes oscillator ready inputs are synchronous to pclk, and that the
 * clock mux downstream follows the registered source select.
 */
`timescale 1ns/1ps

// How it works
// - Fast oscillator status reads 1 only while enabled and ready.
// - External clock status reads 1 only while enabled and ready.
// - Select code 00 fast, 01 external, 10 slow, 11 reserved.
// - Select field reads back the last written code, not the live source.
// - External enable code 11 turns the crystal input into a clock input.
// - Any other external enable code leaves the shared pin as GPIO.
// - Fast oscillator enable bit turns the 16 MHz oscillator off or on.
// - Programming enable forces the fast oscillator on.
// - Programming enable shows fast enable as set, and fast status as set while the fast oscillator is ready.
// - Clearing programming enable brings back the earlier enable and status.
// - Fault flag clears when the latest switch request completed.
// - Fault flag sets on a request toward a disabled or unstable source.
// - Fault flag stays set until the pending switch completes on stability or a new request finds its source usable.
// - Switch register at index 96h, enable register at 97h, both reset 30h.
// - Both registers need a timed-access unlock before each write.
module scss_top
    import scss_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic in_app_program_enable,
    input wire scss_osc_status_t osc_status,
    output scss_osc_ctrl_t osc_ctrl
);

    typedef enum logic {
        SW_RUN,
        SW_WAIT
    } scss_sw_state_t;

    // Bus side state.
    logic rd_valid_q;
    logic [31:0] prdata_q;

    // Software visible control state.
    logic [1:0] ext_clock_enable_q;
    logic fast_osc_enable_q;
    logic [1:0] sel_written_q;

    // Switch engine state.
    scss_sw_state_t sw_state_q;
    scss_sw_state_t sw_state_d;
    scss_src_t active_src_q;
    scss_src_t active_src_d;
    scss_src_t target_q;
    scss_src_t target_d;
    logic switch_fault_flag_q;
    logic switch_fault_flag_d;

    // Registered outputs toward the clock tree.
    scss_osc_ctrl_t osc_ctrl_q;

    // A source is usable only when it is switched on and reports ready.
    function automatic logic src_usable(
        input scss_src_t src,
        input scss_osc_status_t st,
        input logic fast_on,
        input logic ext_on
    );
        case (src)
            SRC_FAST: src_usable = fast_on && st.fast_ready;
            SRC_EXT: src_usable = ext_on && st.ext_ready;
            SRC_SLOW: src_usable = st.slow_ready;
            default: src_usable = 1'b0;
        endcase
    endfunction : src_usable

    // Address decode. Only the three mapped words answer without error.
    wire logic hit_switch = (paddr == scss_reg_addr(SWITCH_IDX));
    wire logic hit_enable = (paddr == scss_reg_addr(ENABLE_IDX));
    wire logic hit_unlock = (paddr == scss_reg_addr(UNLOCK_IDX));
    wire logic addr_hit = hit_switch || hit_enable || hit_unlock;

    // Transfer completion. Writes take effect only at this edge.
    wire logic access_done = psel && penable && pready;
    wire logic wr_take = access_done && pwrite;
    wire logic lane0 = pstrb[0];

    // Timed-access state from the unlock unit.
    wire logic unlocked;

    // Protected writes need byte lane 0 and an open unlock window.
    wire logic wr_switch = wr_take && hit_switch && lane0 && unlocked;
    wire logic wr_enable = wr_take && hit_enable && lane0 && unlocked;
    wire logic wr_key = wr_take && hit_unlock && lane0;

    // Fields carried by the write data.
    wire logic [1:0] sel_wdata = pwdata[SW_SEL_LSB +: 2];
    wire scss_src_t sel_req = scss_src_t'(sel_wdata);
    wire logic [1:0] ext_wdata = pwdata[EN_EXT_LSB +: 2];
    wire logic fast_wdata = pwdata[EN_FAST_BIT];

    // Programming enable overrides the software enable without touching it,
    // so the stored bit is what shows again once programming ends.
    wire logic fast_on = fast_osc_enable_q || in_app_program_enable;
    wire logic fast_en_view = fast_on;
    wire logic ext_on = (ext_clock_enable_q == EXT_ON);

    // Live status bits.
    wire logic fast_osc_stable = fast_on && osc_status.fast_ready;
    wire logic slow_osc_stable = osc_status.slow_ready;
    wire logic ext_clock_stable = ext_on && osc_status.ext_ready;

    // Readiness of a newly requested and of a pending target.
    wire logic req_ok = src_usable(sel_req, osc_status, fast_on, ext_on);
    wire logic tgt_ok = src_usable(target_q, osc_status, fast_on, ext_on);
    wire logic req_valid = (sel_req != SRC_RSVD);

    // Read views of the registers. Reserved bits of the switch register read as
    // zero; those of the enable register read back their reset pattern.
    wire logic [7:0] switch_view = {
        2'h0,
        fast_osc_stable,
        slow_osc_stable,
        ext_clock_stable,
        sel_written_q,
        1'b0
    };
    wire logic [7:0] enable_view = {
        ext_clock_enable_q,
        fast_en_view,
        ENABLE_RST[EN_FAST_BIT-1:EN_FAULT_BIT+1],
        switch_fault_flag_q
    };
    wire logic [7:0] unlock_view = {7'h0, unlocked};

    wire logic [7:0] rd_byte = hit_switch ? switch_view :
                               hit_enable ? enable_view :
                               hit_unlock ? unlock_view : 8'h00;

    // Unlock sequencer; any completed write closes or advances it.
    scss_timed_access u_unlock (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .wr_any(wr_take),
        .wr_key(wr_key),
        .key_data(pwdata[7:0]),
        .unlocked(unlocked)
    );

    // The slave answers in the first access cycle once read data is captured.
    // Holding ready low while frozen keeps the master from completing then.
    assign pready = psel && penable && ce && rd_valid_q;
    assign pslverr = pready && !addr_hit;
    assign prdata = prdata_q;
    assign osc_ctrl = osc_ctrl_q;

    // Read data is sampled every selected cycle so the access sees fresh state.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_valid_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else if (ce)
        begin
            rd_valid_q <= psel && !access_done;
            prdata_q <= psel ? {24'h00_0000, rd_byte} : prdata_q;
        end
    end

    // Enable register. The fast enable bit is held while programming forces
    // the oscillator, so that its earlier value returns afterwards.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_clock_enable_q <= ENABLE_RST[EN_EXT_LSB +: 2];
            fast_osc_enable_q <= ENABLE_RST[EN_FAST_BIT];
        end
        else if (ce && wr_enable)
        begin
            ext_clock_enable_q <= ext_wdata;
            if (!in_app_program_enable)
            begin
                fast_osc_enable_q <= fast_wdata;
            end
        end
    end

    // Select field keeps the code software last wrote, for read-back.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sel_written_q <= SWITCH_RST[SW_SEL_LSB +: 2];
        end
        else if (ce && wr_switch)
        begin
            sel_written_q <= sel_wdata;
        end
    end

    // Switch engine. A new non-reserved request always replaces a pending one. A reserved
    // code is stored for read-back but neither switches nor touches the flag.
    always_comb
    begin
        sw_state_d = sw_state_q;
        active_src_d = active_src_q;
        target_d = target_q;
        switch_fault_flag_d = switch_fault_flag_q;
        if (wr_switch && req_valid)
        begin
            target_d = sel_req;
            if (req_ok)
            begin
                active_src_d = sel_req;
                switch_fault_flag_d = 1'b0;
                sw_state_d = SW_RUN;
            end
            else
            begin
                switch_fault_flag_d = 1'b1;
                sw_state_d = SW_WAIT;
            end
        end
        else
        begin
            case (sw_state_q)
                SW_WAIT:
                begin
                    if (tgt_ok)
                    begin
                        active_src_d = target_q;
                        switch_fault_flag_d = 1'b0;
                        sw_state_d = SW_RUN;
                    end
                end
                default:
                begin
                    sw_state_d = SW_RUN;
                end
            endcase
        end
    end

    // Switch engine registers.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sw_state_q <= SW_RUN;
            active_src_q <= SRC_FAST;
            target_q <= SRC_FAST;
            switch_fault_flag_q <= ENABLE_RST[EN_FAULT_BIT];
        end
        else if (ce)
        begin
            sw_state_q <= sw_state_d;
            active_src_q <= active_src_d;
            target_q <= target_d;
            switch_fault_flag_q <= switch_fault_flag_d;
        end
    end

    // Controls toward the oscillators and mux come from flip-flops, so the
    // mux select changes on one clean edge and never glitches.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            osc_ctrl_q.fast_en <= ENABLE_RST[EN_FAST_BIT];
            osc_ctrl_q.ext_en <= 1'b0;
            osc_ctrl_q.source <= SRC_FAST;
            osc_ctrl_q.switch_pending <= 1'b0;
        end
        else if (ce)
        begin
            osc_ctrl_q.fast_en <= fast_on;
            osc_ctrl_q.ext_en <= ext_on;
            osc_ctrl_q.source <= active_src_d;
            osc_ctrl_q.switch_pending <= (sw_state_d == SW_WAIT);
        end
    end

endmodule : scss_top

/* File: scss_top_sva.sv */
/*
 * Port checker of the system clock source switch.
 * Assumes one pclk domain; it is bound to every scss_top instance.
 */
`timescale 1ns/1ps

module scss_top_sva
    import scss_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic in_app_program_enable,
    input wire scss_osc_status_t osc_status,
    input wire scss_osc_ctrl_t osc_ctrl
);
    // Usable sources indexed by source code, and the decoded bus events. Readiness one
    // cycle back, paired with the registered enables, is what the engine saw before the mux moved.
    scss_osc_status_t status_q;
    wire [3:0] usable = {1'h0, status_q.slow_ready, osc_ctrl.ext_en & status_q.ext_ready,
                         osc_ctrl.fast_en & status_q.fast_ready};
    wire done_wr = psel & penable & pready & pwrite;
    wire mapped = paddr == {2'h0, SWITCH_IDX, 2'h0} || paddr == {2'h0, ENABLE_IDX, 2'h0} ||
                  paddr == {2'h0, UNLOCK_IDX, 2'h0};

    // Oscillator readiness one cycle back, since the mux decides on the cycle before it moves.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            status_q <= '0;
        else
            status_q <= osc_status;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable && ce;
    endsequence
    sequence s_access;
        psel && penable && ce;
    endsequence

    a_zero_wait: assert property (s_setup ##1 s_access |-> pready)
        else $error("access cycle without ready");
    a_err_unmapped: assert property (pready |-> pslverr == !mapped)
        else $error("error response does not match address map");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error response outside access");
    a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_fast_forced: assert property (ce && in_app_program_enable |=> osc_ctrl.fast_en)
        else $error("fast oscillator off during programming");
    // The enable field lands on the write edge and the pad control copies it one edge later.
    a_ext_by_write: assert property ($changed(osc_ctrl.ext_en) |-> $past(done_wr, 2))
        else $error("external enable moved without a write");
    a_clean_switch: assert property ($changed(osc_ctrl.source) |-> usable[osc_ctrl.source])
        else $error("source switched to an unusable clock");
    a_pend_hold: assert property (osc_ctrl.switch_pending ##1 osc_ctrl.switch_pending
                                  |-> $stable(osc_ctrl.source))
        else $error("source moved while switch pending");
    a_pend_ends: assert property ($fell(osc_ctrl.switch_pending)
                                  |-> $changed(osc_ctrl.source) || $past(done_wr))
        else $error("pending switch dropped without completing");
endmodule : scss_top_sva

bind scss_top scss_top_sva u_sva (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .in_app_program_enable(in_app_program_enable), .osc_status(osc_status),
    .osc_ctrl(osc_ctrl));

/* File: scss_top_tb_top.sv */
/*
 * Self-checking bench of scss_top: APB register traffic and oscillator readiness.
 * Assumes the checker file is compiled with it and binds itself to the design.
 */
`timescale 1ns/1ps

module scss_top_tb_top
    import scss_pkg::*;
;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic ce = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [AW-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic in_app_program_enable = 1'h0;
    scss_osc_status_t osc_status = 3'h7;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    scss_osc_ctrl_t osc_ctrl;
    int n_mismatch = 0;
    int total_checks = 0;
    int seed = 22;
    logic [32:0] expq[$];

    scss_top uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .in_app_program_enable(in_app_program_enable), .osc_status(osc_status), .osc_ctrl(osc_ctrl));

    // Free-running bus clock, 40 ns period.
    initial
    begin
        forever #20 pclk = ~pclk;
    end

    task automatic cmp(input string what, input logic [32:0] e, input logic [32:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : cmp

    // One APB transfer; reads leave their expectation for the monitor.
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic [32:0] e);
        logic [31:0] r;
        r = $random(seed);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {r[23:0], d};
        if (!wr)
            expq.push_back(e);
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        // Wait states are the slave's business; only the watchdog ends a hung wait.
        while (pready !== 1'h1)
        begin
            @(posedge pclk);
        end
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask : apb

    task automatic rd(input logic [7:0] idx, input logic [32:0] e);
        apb(1'h0, idx, 8'h00, e);
    endtask : rd

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'h1, idx, d, 33'h0);
    endtask : wr

    // Protected write: both keys first, otherwise the write is dropped.
    task automatic pw(input logic [7:0] idx, input logic [7:0] d);
        wr(UNLOCK_IDX, UNLOCK_KEY1);
        wr(UNLOCK_IDX, UNLOCK_KEY2);
        wr(idx, d);
    endtask : pw

    function automatic logic [32:0] sw_v(input logic f, input logic s, input logic x, input logic [1:0] c);
        return {25'h0, 2'h0, f, s, x, c, 1'h0};
    endfunction : sw_v

    function automatic logic [32:0] en_v(input logic [1:0] x, input logic f, input logic flt);
        return {25'h0, x, f, ENABLE_RST[4:1], flt};
    endfunction : en_v

    // Pad and oscillator controls trail their register by one edge, so they are
    // looked at on the next falling edge, where they have settled.
    task automatic chk(input logic f, input logic x, input scss_src_t s, input logic p);
        @(negedge pclk);
        cmp("osc_ctrl", {28'h0, f, x, s, p}, {28'h0, osc_ctrl});
        @(posedge pclk);
    endtask : chk

    task automatic done(input string t);
        $display("test %s finished", t);
    endtask : done

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up

    // Monitor: every completed read is paired with the oldest expectation.
    always @(posedge pclk)
    begin
        if (psel && penable && pready && !pwrite)
            cmp("read", expq.pop_front(), {pslverr, prdata});
    end

    // Watchdog; the whole sequence needs well under a thousand cycles.
    initial
    begin
        repeat (3000) @(posedge pclk);
        n_mismatch++;
        wrap_up();
    end

    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        chk(1'h1, 1'h0, SRC_FAST, 1'h0);
        rd(SWITCH_IDX, sw_v(1'h1, 1'h1, 1'h0, 2'h0));
        rd(ENABLE_IDX, en_v(2'h0, 1'h1, 1'h0));
        rd(8'h12, {1'h1, 32'h0});
        wr(ENABLE_IDX, 8'hC0);
        rd(ENABLE_IDX, en_v(2'h0, 1'h1, 1'h0));
        done("reset");
        for (int c = 0; c < 4; c++)
        begin
            pw(ENABLE_IDX, {c[1:0], 6'h20});
            chk(1'h1, c == 3, SRC_FAST, 1'h0);
            rd(SWITCH_IDX, sw_v(1'h1, 1'h1, c == 3, 2'h0));
        end
        done("ext_codes");
        // Request the external clock before it is ready.
        osc_status.ext_ready <= 1'h0;
        pw(SWITCH_IDX, 8'h02);
        chk(1'h1, 1'h1, SRC_FAST, 1'h1);
        rd(ENABLE_IDX, en_v(2'h3, 1'h1, 1'h1));
        osc_status.ext_ready <= 1'h1;
        repeat (2) @(posedge pclk);
        chk(1'h1, 1'h1, SRC_EXT, 1'h0);
        rd(ENABLE_IDX, en_v(2'h3, 1'h1, 1'h0));
        rd(SWITCH_IDX, sw_v(1'h1, 1'h1, 1'h1, 2'h1));
        done("pending_switch");
        pw(ENABLE_IDX, 8'hC0);
        chk(1'h0, 1'h1, SRC_EXT, 1'h0);
        rd(SWITCH_IDX, sw_v(1'h0, 1'h1, 1'h1, 2'h1));
        in_app_program_enable <= 1'h1;
        repeat (2) @(posedge pclk);
        chk(1'h1, 1'h1, SRC_EXT, 1'h0);
        rd(ENABLE_IDX, en_v(2'h3, 1'h1, 1'h0));
        rd(SWITCH_IDX, sw_v(1'h1, 1'h1, 1'h1, 2'h1));
        in_app_program_enable <= 1'h0;
        repeat (2) @(posedge pclk);
        rd(ENABLE_IDX, en_v(2'h3, 1'h0, 1'h0));
        rd(SWITCH_IDX, sw_v(1'h0, 1'h1, 1'h1, 2'h1));
        done("programming");
        pw(SWITCH_IDX, 8'h04);
        chk(1'h0, 1'h1, SRC_SLOW, 1'h0);
        pw(SWITCH_IDX, 8'h06);
        chk(1'h0, 1'h1, SRC_SLOW, 1'h0);
        rd(SWITCH_IDX, sw_v(1'h0, 1'h1, 1'h1, 2'h3));
        pw(SWITCH_IDX, 8'h00);
        chk(1'h0, 1'h1, SRC_SLOW, 1'h1);
        pw(ENABLE_IDX, 8'hE0);
        @(posedge pclk);
        chk(1'h1, 1'h1, SRC_FAST, 1'h0);
        rd(ENABLE_IDX, en_v(2'h3, 1'h1, 1'h0));
        done("select_codes");
        wrap_up();
    end
endmodule : scss_top_tb_top
